// *** verilog/bert_regs.svh ***
`ifndef BERT_REGS_SVH
`define BERT_REGS_SVH

`define PAT_511          2'h0
`define PAT_2047         2'h1
`define PAT_QRSS         2'h2
`define LFSR_W           20
`define LFSR_SEED        20'hFFFFF
`define TAP9_A           8
`define TAP9_B           4
`define TAP11_A          10
`define TAP11_B          8
`define TAP20_A          19
`define TAP20_B          16
`define INS_PERIOD       16'h03E8
`define SYNC_CNT         5'h14
`define ERR_HOLD         5'h14
`define SYNC_CNT_W       5

`endif

// *** verilog/bert_pkg.sv ***
`default_nettype none
package bert_pkg;

  typedef logic [1:0] pat_sel_t;

  typedef struct packed {
    logic     enable;
    logic     insert;
    pat_sel_t sel;
  } test_ctl_s;

  typedef struct packed {
    logic in_sync;
    logic ok;
    logic bit_error;
  } check_stat_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_HUNT  = 3'b010,
    ST_LOCK  = 3'b100
  } chk_state_e;

endpackage : bert_pkg
`default_nettype wire

// *** verilog/prbs_step.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "bert_regs.svh"

module prbs_step (
  input  wire logic [19:0]       state_in,
  input  wire bert_pkg::pat_sel_t sel,
  output logic      [19:0]       state_out,
  output logic                   bit_out
);

  logic fb;

  always_comb begin
    unique case (sel)
      `PAT_511: begin
        fb = state_in[`TAP9_A] ^ state_in[`TAP9_B]; // see RQ1
      end
      `PAT_2047: begin
        fb = state_in[`TAP11_A] ^ state_in[`TAP11_B]; // see RQ2
      end
      default: begin
        fb = state_in[`TAP20_A] ^ state_in[`TAP20_B]; // see RQ3
      end
    endcase
    bit_out   = fb;
    state_out = {state_in[`LFSR_W-2:0], fb}; // see RQ15
  end

endmodule : prbs_step
`default_nettype wire

// *** verilog/bit_buffer.sv ***
`timescale 1ns/100ps
`default_nettype none

module bit_buffer (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic in_valid,
  input  wire logic in_data,
  output logic      in_ready,
  output logic      out_valid,
  output logic      out_data,
  input  wire logic out_ready
);

  logic [1:0] mem_ff;
  logic [1:0] nxt_mem;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic       push;
  logic       pop;

  always_comb begin
    in_ready  = (cnt_ff != 2'h2);
    out_valid = (cnt_ff != 2'h0);
    out_data  = mem_ff[0];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    nxt_mem   = mem_ff;
    nxt_cnt   = cnt_ff;
    if (pop) begin
      nxt_mem = {1'b0, mem_ff[1]};
      nxt_cnt = nxt_cnt - 2'h1;
    end
    if (push) begin
      nxt_mem[nxt_cnt[0]] = in_data;
      nxt_cnt             = nxt_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_ff <= 2'h0;
      cnt_ff <= 2'h0;
    end else begin
      mem_ff <= nxt_mem;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : bit_buffer
`default_nettype wire

// *** verilog/bert_engine.sv ***
// How it works
// RQ1 - Selectable 511-bit pseudo-random pattern, generated and checked.
// RQ2 - Selectable 2047-bit pseudo-random pattern, generated and checked.
// RQ3 - Selectable quasi-random pattern from a 2^20 sequence.
// RQ4 - Controller places a loopback before starting any pattern test; ctl.enable starts a test whether or not a loop is active.
// RQ5 - Pattern enable starts the selected pattern; clearing it stops the test.
// RQ6 - Checker reports pass while received bits match the sequence.
// RQ7 - Checker reports bit error when any received bit differs.
// RQ8 - Error insertion deliberately corrupts transmitted bits.
// RQ9 - Terminal drives local loop request to ask for local loopback.
// RQ10 - Terminal drives remote loop request to loop the far unit.
// RQ11 - Test mode indicator asserted while any loopback or pattern test runs.
// RQ12 - Data set ready output held permanently asserted.
// RQ13 - Checker regenerates the sequence with the transmitter polynomial.
// RQ14 - Error indication holds during mismatch, clears once pattern is correct.
// RQ15 - Registers of 9, 11, 20 bits; checker self-synchronises from received bits.
`timescale 1ns/100ps
`default_nettype none
`include "bert_regs.svh"

module bert_engine (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  line_clk,
  input  wire logic                  rx_bit,
  input  wire logic                  local_loop_request,
  input  wire logic                  remote_loop_request,
  input  wire bert_pkg::test_ctl_s   ctl,
  output logic                       tx_bit,
  output logic                       tx_valid,
  input  wire logic                  tx_ready,
  output logic                       local_loop_active,
  output logic                       remote_loop_active,
  output logic                       test_mode_indicator,
  output logic                       data_set_ready,
  output logic                       pattern_ok,
  output logic                       bit_error_result
);

  // Input synchronisers
  logic [1:0] clk_sy_ff;
  logic [1:0] rx_sy_ff;
  logic [1:0] ll_sy_ff;
  logic [1:0] rl_sy_ff;
  logic       clk_prev_ff;
  logic       rise;
  logic       ll_s;
  logic       rl_s;
  logic       rx_s;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clk_sy_ff   <= 2'h0;
      rx_sy_ff    <= 2'h0;
      ll_sy_ff    <= 2'h0;
      rl_sy_ff    <= 2'h0;
      clk_prev_ff <= 1'b0;
    end else begin
      clk_sy_ff   <= {clk_sy_ff[0], line_clk};
      rx_sy_ff    <= {rx_sy_ff[0], rx_bit};
      ll_sy_ff    <= {ll_sy_ff[0], local_loop_request};
      rl_sy_ff    <= {rl_sy_ff[0], remote_loop_request};
      clk_prev_ff <= clk_sy_ff[1];
    end
  end

  always_comb begin
    rise = clk_sy_ff[1] && !clk_prev_ff;
    ll_s = ll_sy_ff[1]; // see RQ9
    rl_s = rl_sy_ff[1]; // see RQ10
    rx_s = rx_sy_ff[1];
  end

  // Control capture
  logic                 en_ff;
  logic                 ins_ff;
  bert_pkg::pat_sel_t   sel_ff;
  logic                 start;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      en_ff  <= 1'b0;
      ins_ff <= 1'b0;
      sel_ff <= `PAT_511;
    end else begin
      en_ff  <= ctl.enable;
      ins_ff <= ctl.insert;
      sel_ff <= ctl.sel;
    end
  end

  always_comb begin
    start = ctl.enable && !en_ff;
  end

  // Generator
  logic [19:0] gen_ff;
  logic [19:0] nxt_gen;
  logic [19:0] gen_step;
  logic        gen_bit;
  logic [15:0] ins_cnt_ff;
  logic [15:0] nxt_ins_cnt;
  logic        buf_in_valid;
  logic        buf_in_data;
  logic        buf_in_ready;
  logic        gen_pend_ff;
  logic        nxt_gen_pend;

  prbs_step u_gen_step (
    .state_in  (gen_ff),
    .sel       (sel_ff),
    .state_out (gen_step),
    .bit_out   (gen_bit)
  );

  always_comb begin
    nxt_gen      = gen_ff;
    nxt_ins_cnt  = ins_cnt_ff;
    nxt_gen_pend = gen_pend_ff;
    buf_in_valid = 1'b0;
    buf_in_data  = gen_bit;
    if (start) begin
      nxt_gen      = `LFSR_SEED; // see RQ5
      nxt_ins_cnt  = 16'h0000;
      nxt_gen_pend = 1'b0;
    end else if (en_ff) begin
      if (rise) begin
        nxt_gen_pend = 1'b1;
      end
      if (gen_pend_ff) begin
        buf_in_valid = 1'b1;
        if (ins_ff && (ins_cnt_ff == `INS_PERIOD)) begin
          buf_in_data = !gen_bit; // see RQ8
        end
        if (buf_in_ready) begin
          nxt_gen      = gen_step;
          nxt_gen_pend = rise;
          nxt_ins_cnt  = (ins_cnt_ff == `INS_PERIOD) ? 16'h0000 : ins_cnt_ff + 16'h0001;
        end
      end
    end else begin
      nxt_gen_pend = 1'b0; // see RQ5
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gen_ff      <= `LFSR_SEED;
      ins_cnt_ff  <= 16'h0000;
      gen_pend_ff <= 1'b0;
    end else begin
      gen_ff      <= nxt_gen;
      ins_cnt_ff  <= nxt_ins_cnt;
      gen_pend_ff <= nxt_gen_pend;
    end
  end

  // Transmit buffer
  logic buf_out_valid;
  logic buf_out_data;
  logic buf_out_ready;
  logic nxt_tx_valid;
  logic nxt_tx_bit;

  bit_buffer u_tx_buf (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (buf_in_valid),
    .in_data   (buf_in_data),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (buf_out_ready)
  );

  always_comb begin
    buf_out_ready = !tx_valid || tx_ready;
    nxt_tx_valid  = tx_valid;
    nxt_tx_bit    = tx_bit;
    if (buf_out_ready) begin
      nxt_tx_valid = buf_out_valid;
      nxt_tx_bit   = buf_out_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_valid <= 1'b0;
      tx_bit   <= 1'b0;
    end else begin
      tx_valid <= nxt_tx_valid;
      tx_bit   <= nxt_tx_bit;
    end
  end

  // Checker
  bert_pkg::chk_state_e         st_ff;
  bert_pkg::chk_state_e         nxt_st;
  logic [19:0]                  chk_ff;
  logic [19:0]                  nxt_chk;
  logic [19:0]                  chk_step;
  logic                         exp_bit;
  logic [`SYNC_CNT_W-1:0]       run_ff;
  logic [`SYNC_CNT_W-1:0]       nxt_run;
  logic                         ok_ff;
  logic                         nxt_ok;
  logic                         be_ff;
  logic                         nxt_be;

  prbs_step u_chk_step (
    .state_in  (chk_ff),
    .sel       (sel_ff),
    .state_out (chk_step),
    .bit_out   (exp_bit)
  );

  always_comb begin
    nxt_st  = st_ff;
    nxt_chk = chk_ff;
    nxt_run = run_ff;
    nxt_ok  = ok_ff;
    nxt_be  = be_ff;
    if (!en_ff) begin
      nxt_st  = bert_pkg::ST_IDLE; // see RQ5
      nxt_run = '0;
      nxt_ok  = 1'b0;
      nxt_be  = 1'b0;
    end else begin
      unique case (st_ff)
        bert_pkg::ST_IDLE: begin
          nxt_st  = bert_pkg::ST_HUNT;
          nxt_run = '0;
          nxt_be  = 1'b1;
        end
        bert_pkg::ST_HUNT: begin
          if (rise) begin
            nxt_chk = {chk_ff[`LFSR_W-2:0], rx_s}; // see RQ15
            if (rx_s == exp_bit) begin // see RQ13
              nxt_run = run_ff + 1'b1;
              if (run_ff == `SYNC_CNT - 1'b1) begin
                nxt_st  = bert_pkg::ST_LOCK;
                nxt_run = '0;
              end
            end else begin
              nxt_run = '0;
            end
          end
        end
        bert_pkg::ST_LOCK: begin
          if (rise) begin
            nxt_chk = chk_step; // see RQ13
            if (rx_s != exp_bit) begin
              nxt_be  = 1'b1; // see RQ7
              nxt_ok  = 1'b0;
              nxt_run = '0;
            end else if (run_ff == `ERR_HOLD - 1'b1) begin
              nxt_be  = 1'b0; // see RQ14
              nxt_ok  = 1'b1; // see RQ6
            end else begin
              nxt_run = run_ff + 1'b1;
            end
            if (rx_s != exp_bit && run_ff == '0 && be_ff && !ok_ff) begin
              nxt_st = bert_pkg::ST_HUNT; // see RQ14
            end
          end
        end
        default: begin
          nxt_st = bert_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff  <= bert_pkg::ST_IDLE;
      chk_ff <= `LFSR_SEED;
      run_ff <= '0;
      ok_ff  <= 1'b0;
      be_ff  <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      chk_ff <= nxt_chk;
      run_ff <= nxt_run;
      ok_ff  <= nxt_ok;
      be_ff  <= nxt_be;
    end
  end

  // Status outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      local_loop_active   <= 1'b0;
      remote_loop_active  <= 1'b0;
      test_mode_indicator <= 1'b0;
      data_set_ready      <= 1'b1;
      pattern_ok          <= 1'b0;
      bit_error_result    <= 1'b0;
    end else begin
      local_loop_active   <= ll_s; // see RQ4
      remote_loop_active  <= rl_s;
      test_mode_indicator <= ll_s || rl_s || en_ff; // see RQ11
      data_set_ready      <= 1'b1; // see RQ12
      pattern_ok          <= ok_ff; // see RQ6
      bit_error_result    <= be_ff; // see RQ7
    end
  end

endmodule : bert_engine
`default_nettype wire

// *** sim/bert_engine_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module bert_engine_chk (
  input wire logic                clk_sys,
  input wire logic                reset,
  input wire logic                local_loop_request,
  input wire logic                remote_loop_request,
  input wire bert_pkg::test_ctl_s ctl,
  input wire logic                tx_bit,
  input wire logic                tx_valid,
  input wire logic                tx_ready,
  input wire logic                local_loop_active,
  input wire logic                remote_loop_active,
  input wire logic                test_mode_indicator,
  input wire logic                data_set_ready,
  input wire logic                pattern_ok,
  input wire logic                bit_error_result
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_dsr; data_set_ready; endproperty
  a_dsr: assert property (p_dsr) else $error("dsr low");
  property p_excl; !(pattern_ok && bit_error_result); endproperty
  a_excl: assert property (p_excl) else $error("pass and error together");
  property p_ll; local_loop_request [*8] |-> local_loop_active; endproperty
  a_ll: assert property (p_ll) else $error("local loop not taken");
  property p_rl; remote_loop_request [*8] |-> remote_loop_active; endproperty
  a_rl: assert property (p_rl) else $error("remote loop not taken");
  property p_tm; local_loop_active || remote_loop_active |-> ##[0:1] test_mode_indicator;
  endproperty
  a_tm: assert property (p_tm) else $error("test mode missing");
  property p_tm_off;
    (!local_loop_active && !remote_loop_active && !ctl.enable) [*3] |-> !test_mode_indicator;
  endproperty
  a_tm_off: assert property (p_tm_off) else $error("test mode stuck");
  property p_start; $rose(ctl.enable) |-> ##[1:3] (bit_error_result && test_mode_indicator);
  endproperty
  a_start: assert property (p_start) else $error("no error at start");
  property p_idle; !ctl.enable [*4] |-> !(pattern_ok || bit_error_result); endproperty
  a_idle: assert property (p_idle) else $error("result after stop");
  property p_clear; $rose(pattern_ok) |-> $fell(bit_error_result); endproperty
  a_clear: assert property (p_clear) else $error("error not cleared");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_bit); endproperty
  a_hold: assert property (p_hold) else $error("tx word lost");
endmodule : bert_engine_chk
bind bert_engine bert_engine_chk i_bert_engine_chk (.clk_sys, .reset, .local_loop_request,
  .remote_loop_request, .ctl, .tx_bit, .tx_valid, .tx_ready, .local_loop_active,
  .remote_loop_active,
  .test_mode_indicator, .data_set_ready, .pattern_ok, .bit_error_result);
`default_nettype wire

// *** sim/bert_far_end.sv ***
`timescale 1ns/100ps
`default_nettype none
module bert_far_end (
  input wire logic clk_sys,
  input wire logic tx_bit,
  input wire logic tx_valid,
  input wire logic stall,
  input wire logic corrupt,
  output logic     tx_ready,
  output logic     line_clk,
  output logic     rx_bit
);
  bit q[$];
  bit hist[$];
  assign tx_ready = !stall;
  initial begin
    line_clk = 1'b0;
    rx_bit = 1'b0;
    #3;
    forever #40 line_clk = ~line_clk;
  end
  // Accept sent bits into the loop
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) begin
      q.push_back(tx_bit);
      hist.push_back(tx_bit);
    end
  end
  // Echo back, toggle when nothing pending
  always @(negedge line_clk) begin
    if (q.size() > 0) rx_bit <= q.pop_front() ^ corrupt;
    else rx_bit <= ~rx_bit;
  end
endmodule : bert_far_end
`default_nettype wire

// *** sim/prbs_bit_error_rate_tester_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "bert_regs.svh"
module prbs_bit_error_rate_tester_tb;
  logic clk_sys, reset, local_loop_request, remote_loop_request, stall, corrupt;
  logic line_clk, rx_bit, tx_bit, tx_valid, tx_ready, local_loop_active;
  logic remote_loop_active, test_mode_indicator, data_set_ready, pattern_ok;
  logic bit_error_result;
  bert_pkg::test_ctl_s ctl;
  bert_pkg::pat_sel_t  sels[3] = '{`PAT_511, `PAT_2047, `PAT_QRSS};
  int                  len[3] = '{9, 11, 20};
  int                  tap[3] = '{5, 9, 17};
  int                  err_count;
  int                  n_checks;
  bert_engine i_bert_engine (.clk_sys, .reset, .line_clk, .rx_bit, .local_loop_request,
    .remote_loop_request, .ctl, .tx_bit, .tx_valid, .tx_ready, .local_loop_active,
    .remote_loop_active, .test_mode_indicator, .data_set_ready, .pattern_ok,
    .bit_error_result);
  bert_far_end i_bert_far_end (.clk_sys, .tx_bit, .tx_valid, .stall, .corrupt, .tx_ready,
    .line_clk, .rx_bit);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic wait_hi(input bit want_ok);
    int n;
    n = 0;
    while ((want_ok ? pattern_ok : bit_error_result) !== 1'b1 && n < 12000) begin
      @(negedge clk_sys);
      n++;
    end
    check(n < 12000, 1'b1);
  endtask : wait_hi
  // Sent stream obeys the recurrence or its mirror
  function automatic bit rec_ok(input int l, input int a);
    bit h[$];
    bit ga;
    bit gb;
    h = i_bert_far_end.hist;
    ga = 1'b1;
    gb = 1'b1;
    for (int n = l; n < h.size(); n++) begin
      ga &= h[n] == (h[n-l] ^ h[n-a]);
      gb &= h[n] == (h[n-l] ^ h[n-l+a]);
    end
    return (ga || gb) && h.size() > 2 * l;
  endfunction : rec_ok
  initial begin
    #400000;
    err_count++;
    conclude();
  end
  initial begin
    err_count = 0;
    n_checks = 0;
    reset = 1'b1;
    stall = 1'b0;
    corrupt = 1'b0;
    ctl = '0;
    local_loop_request = 1'b0;
    remote_loop_request = 1'b0;
    void'($urandom(32'h69BF));
    cyc(8);
    reset = 1'b0;
    cyc(2);
    check(data_set_ready, 1'b1);
    check(test_mode_indicator, 1'b0);
    local_loop_request = 1'b1;
    cyc(8);
    check(local_loop_active, 1'b1);
    check(test_mode_indicator, 1'b1);
    for (int s = 0; s < 3; s++) begin
      ctl.sel = sels[s];
      ctl.enable = 1'b1;
      i_bert_far_end.hist.delete();
      cyc(4);
      check(bit_error_result, 1'b1);
      wait_hi(1'b1);
      check(pattern_ok, 1'b1);
      check(bit_error_result, 1'b0);
      stall = 1'b1;
      cyc($urandom_range(80, 200));
      stall = 1'b0;
      wait_hi(1'b0);
      check(pattern_ok, 1'b0);
      wait_hi(1'b1);
      check(pattern_ok, 1'b1);
      cyc($urandom_range(1, 50));
      corrupt = 1'b1;
      cyc(10);
      corrupt = 1'b0;
      wait_hi(1'b0);
      check(bit_error_result, 1'b1);
      wait_hi(1'b1);
      check(bit_error_result, 1'b0);
      check(rec_ok(len[s], tap[s]), 1'b1);
      ctl.enable = 1'b0;
      cyc(4);
      check(pattern_ok | bit_error_result, 1'b0);
    end
    local_loop_request = 1'b0;
    remote_loop_request = 1'b1;
    cyc(8);
    check(remote_loop_active, 1'b1);
    check(test_mode_indicator, 1'b1);
    ctl.insert = 1'b1;
    ctl.enable = 1'b1;
    wait_hi(1'b1);
    check(pattern_ok, 1'b1);
    wait_hi(1'b0);
    check(bit_error_result, 1'b1);
    ctl = '0;
    remote_loop_request = 1'b0;
    cyc(8);
    check(test_mode_indicator, 1'b0);
    conclude();
  end
endmodule : prbs_bit_error_rate_tester_tb
`default_nettype wire
